// [inc/smos_pkg.sv]
// Purpose: shared constants and carriers of the sync monitor output block
// Assumes: 20 MHz system clock, 32-bit classic Wishbone slave
// Notes:   monitor source numbering is shared by the top and the selector
package smos_pkg;
    localparam int unsigned CLK_MHZ        = 20;
    localparam int unsigned TIMER_TICK_NS  = 16;
    localparam int unsigned TIMER_TICK_RAW = (TIMER_TICK_NS * CLK_MHZ) / 1000;
    // tick time rounds down, never below one cycle
    localparam int unsigned TIMER_TICK_CYC = (TIMER_TICK_RAW < 1) ? 1 : TIMER_TICK_RAW;
    localparam int unsigned TIMER_BITS     = 27;
    localparam int unsigned SWEEP_BITS     = 32;
    localparam int unsigned TAG_BITS       = 8;
    localparam int unsigned SEL_BITS       = 7;
    localparam int unsigned SRC_COUNT      = 128;

    // register byte offsets
    localparam logic [7:0] REG_FAST_SEL   = 8'h00;
    localparam logic [7:0] REG_TTL_SEL    = 8'h04;
    localparam logic [7:0] REG_CTRL       = 8'h08;
    localparam logic [7:0] REG_PRESET     = 8'h0c;
    localparam logic [7:0] REG_SWEEP_CNT  = 8'h10;
    localparam logic [7:0] REG_STATUS     = 8'h14;
    localparam logic [7:0] REG_LAST_TAG   = 8'h18;

    // control fields
    localparam int unsigned CTRL_PRESET_EN = 0;
    localparam int unsigned CTRL_TAG_EN    = 1;
    localparam int unsigned CTRL_RELOAD    = 2;

    // monitor source numbers
    localparam logic [6:0] SRC_START      = 7'h00;
    localparam logic [6:0] SRC_STOP       = 7'h01;
    localparam logic [6:0] SRC_ON         = 7'h02;
    localparam logic [6:0] SRC_WINDOW     = 7'h03;
    localparam logic [6:0] SRC_TAP        = 7'h04;
    localparam logic [6:0] SRC_BURST_FULL = 7'h05;
    localparam logic [6:0] SRC_BULK_FULL  = 7'h06;
    localparam logic [6:0] SRC_TIMER0     = 7'h07;
    localparam logic [6:0] SRC_SWEEP0     = 7'h22;

    // reset values
    localparam logic [6:0]  SEL_RESET      = 7'h02;
    localparam logic [31:0] SWEEP_ALL_ONES = 32'hffffffff;
    localparam logic [31:0] SWEEP_ZERO     = 32'h00000000;

    typedef struct packed {
        logic bulk_full;
        logic burst_full;
        logic tap;
        logic window;
        logic on;
        logic stop;
        logic start;
    } smos_misc_s;

    typedef struct packed {
        logic [7:0]  tag;
        logic [23:0] time_low;
    } smos_record_s;
endpackage : smos_pkg

// [hw/smos_select.sv]
// Purpose: one monitor output: source selection, routing limit and polarity
// Assumes: sources and select come from logic on the same clock
// Notes:   output is registered, one cycle behind the source
`timescale 1ns/1ps
module smos_select #(
    parameter bit FAST_PORT = 1'b1
) (
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic [smos_pkg::SRC_COUNT-1:0]     src_i,
    input  wire logic [smos_pkg::SEL_BITS-1:0]      sel_i,
    output logic                                    mon_o
);
    logic chosen;
    logic allowed;
    logic next_mon;

    always_comb begin
        chosen  = src_i[sel_i];
        allowed = FAST_PORT
               || !((sel_i == smos_pkg::SRC_START) || (sel_i == smos_pkg::SRC_STOP)
                    || (sel_i == smos_pkg::SRC_TAP));
        // fast port drives low for an asserted source
        next_mon = FAST_PORT ? ~(chosen & allowed) : (chosen & allowed);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mon_o <= FAST_PORT;
        end else begin
            mon_o <= next_mon;
        end
    end
endmodule : smos_select

// [hw/smos_top.sv]
// Purpose: sync monitor outputs, sweep counter, sweep timer and tag capture
// Assumes: sweep, window and buffer-full levels come from same-clock logic
// Notes:   timer and tap run at the fastest rate the system clock allows
// How it works
// - events taken on falling input edges
// - start or stop selectable directly
// - sweep-active source high during sweep
// - window source asserted during acquisition window
// - timebase square tap selectable
// - burst buffer full selectable
// - bulk buffer full selectable
// - timer bits 0..26, only during sweep
// - each sweep counter bit selectable
// - 32-bit sweep counter counts sweeps
// - preset loads all-ones minus preset
// - without preset counter starts at zero
// - start, stop, tap only on fast
// - fast output is negative logic
// - 8-bit tag input captured
// - stop records feed two-stage buffering
// - each event counted exactly once
// - timer bit 0 toggles each tick
// - tag sampled with each stop
// - tag replaces upper time byte
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module smos_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        start_n_i,
    input  wire logic        stop_n_i,
    input  wire logic [7:0]  tag_i,
    input  wire logic        sweep_on_i,
    input  wire logic        window_i,
    input  wire logic        burst_buffer_full_i,
    input  wire logic        bulk_buffer_full_i,
    input  wire logic [31:0] time_data_i,
    output logic [31:0]      stop_record_o,
    output logic             stop_record_valid_o,
    output logic             mon_fast_o,
    output logic             mon_ttl_o
);
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // pin synchronisers: first stage read only by the second
    logic        start_meta;
    logic        start_sync;
    logic        start_prev;
    logic        stop_meta;
    logic        stop_sync;
    logic        stop_prev;
    logic [7:0]  tag_meta;
    logic [7:0]  tag_sync;
    logic        next_start_meta;
    logic        next_start_sync;
    logic        next_start_prev;
    logic        next_stop_meta;
    logic        next_stop_sync;
    logic        next_stop_prev;
    logic [7:0]  next_tag_meta;
    logic [7:0]  next_tag_sync;

    always_comb begin
        next_start_meta = start_n_i;
        next_start_sync = start_meta;
        next_start_prev = start_sync;
        next_stop_meta  = stop_n_i;
        next_stop_sync  = stop_meta;
        next_stop_prev  = stop_sync;
        next_tag_meta   = tag_i;
        next_tag_sync   = tag_meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_meta <= 1'b1;
            start_sync <= 1'b1;
            start_prev <= 1'b1;
            stop_meta  <= 1'b1;
            stop_sync  <= 1'b1;
            stop_prev  <= 1'b1;
            tag_meta   <= 8'h00;
            tag_sync   <= 8'h00;
        end else begin
            start_meta <= next_start_meta;
            start_sync <= next_start_sync;
            start_prev <= next_start_prev;
            stop_meta  <= next_stop_meta;
            stop_sync  <= next_stop_sync;
            stop_prev  <= next_stop_prev;
            tag_meta   <= next_tag_meta;
            tag_sync   <= next_tag_sync;
        end
    end

    // one pulse per falling edge, so an event never lands twice
    logic stop_event;
    assign stop_event = stop_prev & ~stop_sync;

    // register file
    logic [6:0]  fast_sel;
    logic [6:0]  ttl_sel;
    logic        preset_en;
    logic        tag_en;
    logic [31:0] preset_val;
    logic [31:0] sweep_cnt;
    logic [7:0]  last_tag;
    logic        ack;
    logic [31:0] rdata;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic [6:0]  next_fast_sel;
    logic [6:0]  next_ttl_sel;
    logic        next_preset_en;
    logic        next_tag_en;
    logic [31:0] next_preset_val;
    logic        reload;
    logic        bus_req;
    logic        bus_wr;
    logic [31:0] ctrl_word;
    logic [31:0] merged;

    always_comb begin
        bus_req         = wb_cyc_i & wb_stb_i & ~ack;
        bus_wr          = bus_req & wb_we_i;
        next_ack        = bus_req;
        next_rdata      = rdata;
        next_fast_sel   = fast_sel;
        next_ttl_sel    = ttl_sel;
        next_preset_en  = preset_en;
        next_tag_en     = tag_en;
        next_preset_val = preset_val;
        reload          = 1'b0;
        ctrl_word       = 32'h00000000;
        ctrl_word[smos_pkg::CTRL_PRESET_EN] = preset_en;
        ctrl_word[smos_pkg::CTRL_TAG_EN]    = tag_en;
        merged          = 32'h00000000;
        if (bus_req) begin
            case (wb_adr_i)
                smos_pkg::REG_FAST_SEL:  next_rdata = {25'h0000000, fast_sel};
                smos_pkg::REG_TTL_SEL:   next_rdata = {25'h0000000, ttl_sel};
                smos_pkg::REG_CTRL:      next_rdata = ctrl_word;
                smos_pkg::REG_PRESET:    next_rdata = preset_val;
                smos_pkg::REG_SWEEP_CNT: next_rdata = sweep_cnt;
                smos_pkg::REG_STATUS:    next_rdata = {28'h0000000, bulk_buffer_full_i,
                                                       burst_buffer_full_i, window_i,
                                                       sweep_on_i};
                smos_pkg::REG_LAST_TAG:  next_rdata = {24'h000000, last_tag};
                default:                 next_rdata = 32'h00000000;
            endcase
        end
        if (bus_wr) begin
            case (wb_adr_i)
                smos_pkg::REG_FAST_SEL: begin
                    merged        = merge_bytes({25'h0000000, fast_sel}, wb_dat_i, wb_sel_i);
                    next_fast_sel = merged[6:0];
                end
                smos_pkg::REG_TTL_SEL: begin
                    merged       = merge_bytes({25'h0000000, ttl_sel}, wb_dat_i, wb_sel_i);
                    next_ttl_sel = merged[6:0];
                end
                smos_pkg::REG_CTRL: begin
                    merged         = merge_bytes(ctrl_word, wb_dat_i, wb_sel_i);
                    next_preset_en = merged[smos_pkg::CTRL_PRESET_EN];
                    next_tag_en    = merged[smos_pkg::CTRL_TAG_EN];
                    reload         = wb_sel_i[0] & wb_dat_i[smos_pkg::CTRL_RELOAD];
                end
                smos_pkg::REG_PRESET: begin
                    next_preset_val = merge_bytes(preset_val, wb_dat_i, wb_sel_i);
                end
                default: begin
                    merged = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack        <= 1'b0;
            rdata      <= 32'h00000000;
            fast_sel   <= smos_pkg::SEL_RESET;
            ttl_sel    <= smos_pkg::SEL_RESET;
            preset_en  <= 1'b0;
            tag_en     <= 1'b0;
            preset_val <= 32'h00000000;
        end else begin
            ack        <= next_ack;
            rdata      <= next_rdata;
            fast_sel   <= next_fast_sel;
            ttl_sel    <= next_ttl_sel;
            preset_en  <= next_preset_en;
            tag_en     <= next_tag_en;
            preset_val <= next_preset_val;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

    // sweep counter; reload wins over a sweep in the same cycle
    logic        sweep_prev;
    logic [31:0] next_sweep_cnt;

    always_comb begin
        next_sweep_cnt = sweep_cnt;
        if (reload) begin
            // an enable written together with reload already counts
            next_sweep_cnt = next_preset_en ? (smos_pkg::SWEEP_ALL_ONES - preset_val)
                                            : smos_pkg::SWEEP_ZERO;
        end else if (sweep_on_i && !sweep_prev) begin
            // holds at all ones once a preset run is complete
            if (!(preset_en && (sweep_cnt == smos_pkg::SWEEP_ALL_ONES))) begin
                next_sweep_cnt = sweep_cnt + 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sweep_prev <= 1'b0;
            sweep_cnt  <= smos_pkg::SWEEP_ZERO;
        end else begin
            sweep_prev <= sweep_on_i;
            sweep_cnt  <= next_sweep_cnt;
        end
    end

    // sweep timer: tick enable from a divider, cleared outside a sweep
    logic [3:0]  tick_div;
    logic        tick;
    logic [26:0] timer;
    logic [3:0]  next_tick_div;
    logic [26:0] next_timer;
    logic        tap;
    logic        next_tap;

    always_comb begin
        tick          = (tick_div == 4'(smos_pkg::TIMER_TICK_CYC - 1));
        next_tick_div = tick ? 4'h0 : tick_div + 4'h1;
        next_timer    = timer;
        next_tap      = ~tap;
        if (!sweep_on_i) begin
            next_timer    = 27'h0000000;
            next_tick_div = 4'h0;
        end else if (tick) begin
            next_timer = timer + 27'h0000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_div <= 4'h0;
            timer    <= 27'h0000000;
            tap      <= 1'b0;
        end else begin
            tick_div <= next_tick_div;
            timer    <= next_timer;
            tap      <= next_tap;
        end
    end

    // stop record: tag sampled with the stop that produced it
    smos_pkg::smos_record_s next_record;
    logic                   next_valid;
    logic [7:0]             next_last_tag;

    always_comb begin
        next_record.tag      = tag_en ? tag_sync : time_data_i[31:24];
        next_record.time_low = time_data_i[23:0];
        next_valid           = stop_event;
        next_last_tag        = stop_event ? tag_sync : last_tag;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_record_o       <= 32'h00000000;
            stop_record_valid_o <= 1'b0;
            last_tag            <= 8'h00;
        end else begin
            if (stop_event) begin
                stop_record_o <= next_record;
            end
            stop_record_valid_o <= next_valid;
            last_tag            <= next_last_tag;
        end
    end

    // monitor source vector
    smos_pkg::smos_misc_s         misc;
    logic [smos_pkg::SRC_COUNT-1:0] src;

    always_comb begin
        misc.start      = ~start_sync;
        misc.stop       = ~stop_sync;
        misc.on         = sweep_on_i;
        misc.window     = window_i;
        misc.tap        = tap;
        misc.burst_full = burst_buffer_full_i;
        misc.bulk_full  = bulk_buffer_full_i;
    end

    genvar k;
    generate
        for (k = 0; k < smos_pkg::SRC_COUNT; k++) begin : g_src
            if (k < int'(smos_pkg::SRC_TIMER0)) begin : g_misc
                assign src[k] = misc[k];
            end else if (k < int'(smos_pkg::SRC_SWEEP0)) begin : g_timer
                assign src[k] = timer[k - int'(smos_pkg::SRC_TIMER0)] & sweep_on_i;
            end else if (k < int'(smos_pkg::SRC_SWEEP0) + 32) begin : g_sweep
                assign src[k] = sweep_cnt[k - int'(smos_pkg::SRC_SWEEP0)];
            end else begin : g_none
                assign src[k] = 1'b0;
            end
        end
    endgenerate

    smos_select #(.FAST_PORT(1'b1)) u_fast (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .src_i (src),
        .sel_i (fast_sel),
        .mon_o (mon_fast_o)
    );

    smos_select #(.FAST_PORT(1'b0)) u_ttl (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .src_i (src),
        .sel_i (ttl_sel),
        .mon_o (mon_ttl_o)
    );
endmodule : smos_top

// [bench/smos_assertions.sv]
// Purpose: port-level checks of the sync monitor block
// Assumes: one clock, synchronous active-high reset
// Notes:   select state is internal, so routing is judged in the bench
`timescale 1ns/1ps
module smos_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        stop_n_i,
    input wire logic        stop_record_valid_o,
    input wire logic        mon_fast_o,
    input wire logic        mon_ttl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_idle;
        !(wb_cyc_i && wb_stb_i) && !wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");
    property p_stop_lat;
        $fell(stop_n_i) |-> ##[2:4] stop_record_valid_o;
    endproperty
    a_stop_lat: assert property (p_stop_lat) else $error("no stop record");
    property p_valid_once;
        stop_record_valid_o |=> !stop_record_valid_o;
    endproperty
    a_valid_once: assert property (p_valid_once) else $error("record twice");
    property p_no_spur;
        stop_n_i [*6] |-> !stop_record_valid_o;
    endproperty
    a_no_spur: assert property (p_no_spur) else $error("record no edge");
    property p_rst_bus;
        disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0 && !stop_record_valid_o;
    endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("bus not reset");
    property p_rst_mon;
        disable iff (1'b0) rst_i |=> mon_fast_o && !mon_ttl_o;
    endproperty
    a_rst_mon: assert property (p_rst_mon) else $error("monitor not idle");
    c_rec: cover property (stop_record_valid_o);
    c_fast: cover property (!mon_fast_o);
    c_ttl: cover property (mon_ttl_o);
endmodule : smos_assertions

bind smos_top smos_assertions chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_n_i(stop_n_i),
    .stop_record_valid_o(stop_record_valid_o), .mon_fast_o(mon_fast_o),
    .mon_ttl_o(mon_ttl_o)
);

// [bench/smos_scope.sv]
// Purpose: scope on both monitor outputs, edge counts of both and the active level of the fast one
// Assumes: outputs are sampled on the system clock
// Notes:   edge counts near a clear may be off by one
`timescale 1ns/1ps
module smos_scope (
    input  wire logic  clk_i,
    input  wire logic  clr_i,
    input  wire logic  fast_i,
    input  wire logic  ttl_i,
    output logic       fast_act_o,
    output logic [7:0] fast_edges_o,
    output logic [7:0] ttl_edges_o
);
    logic fast_q;
    logic ttl_q;
    assign fast_act_o = !fast_i;
    always @(posedge clk_i) begin
        fast_q <= fast_i;
        ttl_q <= ttl_i;
        if (clr_i) begin
            fast_edges_o <= 8'h00;
            ttl_edges_o <= 8'h00;
        end else begin
            fast_edges_o <= fast_edges_o + 8'(fast_i !== fast_q);
            ttl_edges_o <= ttl_edges_o + 8'(ttl_i !== ttl_q);
        end
    end
endmodule : smos_scope

// [bench/tb.sv]
// Purpose: self-checking bench of the sync monitor block
// Assumes: one-cycle Wishbone answer, one-cycle monitor delay
// Notes:   tap and timer run at clock rate, so edges are counted
`timescale 1ns/1ps
module tb;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 0;
    logic [7:0]  adr = 8'h00, tag = 8'h00, fe, te;
    logic [3:0]  lv = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, tdat = 32'h12345678, rec, q;
    logic        ack, vld, fast, ttl, fact, st_n = 1, sp_n = 1;
    int          fails = 0, n_compared = 0, cycles = 0;
    always #25 clk_i = ~clk_i;
    smos_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .start_n_i(st_n), .stop_n_i(sp_n), .tag_i(tag),
        .sweep_on_i(lv[0]), .window_i(lv[1]), .burst_buffer_full_i(lv[2]),
        .bulk_buffer_full_i(lv[3]), .time_data_i(tdat), .stop_record_o(rec),
        .stop_record_valid_o(vld), .mon_fast_o(fast), .mon_ttl_o(ttl));
    smos_scope scope_u (.clk_i(clk_i), .clr_i(clr), .fast_i(fast), .ttl_i(ttl),
        .fast_act_o(fact), .fast_edges_o(fe), .ttl_edges_o(te));
    task automatic stop_test();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_n
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 0; stb <= 0;
        chk(n, 2, "ack delay");
    endtask : wb
    task automatic sel_both(input logic [6:0] s);
        wb(1, smos_pkg::REG_FAST_SEL, {25'h0, s});
        wb(1, smos_pkg::REG_TTL_SEL, {25'h0, s});
        wait_n(3);
    endtask : sel_both
    task automatic t_regs();
        wb(0, smos_pkg::REG_FAST_SEL, 0); chk(q, 32'h2, "fast sel reset");
        wb(0, smos_pkg::REG_TTL_SEL, 0); chk(q, 32'h2, "ttl sel reset");
        wb(1, 8'h1c, 32'hffffffff); wb(0, 8'h1c, 0); chk(q, 0, "unmapped");
    endtask : t_regs
    task automatic t_levels();
        logic [6:0] tab [4];
        tab = '{smos_pkg::SRC_ON, smos_pkg::SRC_WINDOW, smos_pkg::SRC_BURST_FULL,
                smos_pkg::SRC_BULK_FULL};
        for (int i = 0; i < 4; i++) begin
            sel_both(tab[i]);
            lv <= 4'(1 << i);
            wait_n(3);
            chk({fact, ttl}, 2'b11, "level on");
            wb(0, smos_pkg::REG_STATUS, 0); chk(q, 1 << i, "status");
            lv <= 4'h0;
            wait_n(3);
            chk({fact, ttl}, 2'b00, "level off");
        end
    endtask : t_levels
    task automatic t_fast_only();
        for (int i = 0; i < 2; i++) begin
            sel_both(i ? smos_pkg::SRC_STOP : smos_pkg::SRC_START);
            st_n <= 0; sp_n <= 0;
            wait_n(5);
            chk({fact, ttl}, 2'b10, "event pin low");
            st_n <= 1; sp_n <= 1;
            wait_n(5);
            chk({fact, ttl}, 2'b00, "event pin high");
        end
        sel_both(smos_pkg::SRC_TAP);
        clr <= 1; wait_n(1); clr <= 0; wait_n(10);
        chk({fe > 8, te}, 9'h100, "tap edges");
    endtask : t_fast_only
    task automatic t_timer();
        int e;
        lv <= 4'h1;
        for (int k = 0; k < 4; k++) begin
            sel_both(7'(smos_pkg::SRC_TIMER0 + k));
            clr <= 1; wait_n(1); clr <= 0; wait_n(16);
            e = (16 >> k) - int'(te);
            chk(e >= -1 && e <= 1, 1, "timer rate");
        end
        lv <= 4'h0;
        wait_n(2); clr <= 1; wait_n(1); clr <= 0; wait_n(8);
        chk({te, ttl}, 0, "timer idle");
    endtask : t_timer
    task automatic sweeps(input int n);
        repeat (n) begin
            lv <= 4'h1; wait_n(2); lv <= 4'h0; wait_n(2);
        end
    endtask : sweeps
    task automatic t_sweep();
        wb(1, smos_pkg::REG_CTRL, 32'h4); sweeps(3);
        wb(1, smos_pkg::REG_TTL_SEL, {25'h0, 7'(smos_pkg::SRC_SWEEP0 + 1)}); wait_n(3);
        chk(ttl, 1, "sweep bit1");
        wb(1, smos_pkg::REG_TTL_SEL, {25'h0, 7'(smos_pkg::SRC_SWEEP0 + 2)}); wait_n(3);
        chk(ttl, 0, "sweep bit2");
        wb(0, smos_pkg::REG_SWEEP_CNT, 0); chk(q, 32'h3, "count");
        wb(1, smos_pkg::REG_SWEEP_CNT, 0); wb(0, smos_pkg::REG_SWEEP_CNT, 0);
        chk(q, 32'h3, "count ro");
        wb(1, smos_pkg::REG_PRESET, 32'h2); wb(1, smos_pkg::REG_CTRL, 32'h5);
        wb(0, smos_pkg::REG_SWEEP_CNT, 0); chk(q, 32'hfffffffd, "preset load");
        wb(0, smos_pkg::REG_CTRL, 0); chk(q, 32'h1, "ctrl readback");
        wb(0, smos_pkg::REG_PRESET, 0); chk(q, 32'h2, "preset readback");
        sweeps(3);
        wb(0, smos_pkg::REG_SWEEP_CNT, 0); chk(q, 32'hffffffff, "preset end");
    endtask : t_sweep
    task automatic t_stop(input logic [31:0] c, input logic [31:0] exp);
        int n;
        n = 0;
        wb(1, smos_pkg::REG_CTRL, c);
        tag <= 8'ha5; wait_n(3); sp_n <= 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (vld !== 1'b1 && n < 10);
        chk(rec, exp, "stop record");
        sp_n <= 1; wait_n(4);
        wb(0, smos_pkg::REG_LAST_TAG, 0); chk(q, 32'ha5, "last tag");
    endtask : t_stop
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end
    initial begin
        wait_n(2);
        rst_i <= 0;
        t_regs();
        t_levels();
        t_fast_only();
        t_timer();
        t_sweep();
        t_stop(32'h2, 32'ha5345678);
        t_stop(32'h0, 32'h12345678);
        stop_test();
    end
endmodule : tb
